// ### rtl/scd_dma.sv
// Single channel DMA controller: register port, bus master, chains
//
// What this block does
// [RQ1] Interrupt on ready, match, end of block
// [RQ2] Enabled condition sets pending, may alter vector
// [RQ3] Match at block end is second-last byte's
// [RQ4] Acknowledge places 8-bit vector on data
// [RQ5] Pulse every 256 bytes, first offset 1-255
// [RQ6] Pulses only while bus requested and granted
// [RQ7] Address bus: source on read, destination write
// [RQ8] Grant input low means buses released
// [RQ9] Pass grant down only when not requesting
// [RQ10] Open-drain request; wait while others hold it
// [RQ11] Wait input stretches owned read/write cycles
// [RQ12] Chip enable with write strobe loads byte
// [RQ13] Chain out high: chain in, not serviced
// [RQ14] Open-drain interrupt; acknowledge by strobe+fetch
// [RQ15] Return opcode pair ends in-service state
// [RQ16] I/O strobe selects input, marks port output
// [RQ17] Memory strobe low for owned memory access
// [RQ18] Read/write inputs when idle, outputs owning
// [RQ19] Ready polarity programmable, gates bus request
// [RQ20] Seven groups, base bytes point at associates
// [RQ21] Status bytes read in turn, masked skipped
// [RQ22] Byte counter compared with block length
// [RQ23] Burst releases, continuous pauses, byte releases
// [RQ24] Transfers length plus one bytes
// [RQ25] Reset or control write disables requests
// [RQ26] Associates load in fixed order per base
`timescale 1ns/10ps
`default_nettype none
module scd_dma (
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic [7:0] data_i,
	output logic [7:0] data_o,
	output logic data_oe,
	output logic [15:0] addr_o,
	output logic addr_oe,
	output logic mem_strobe_n_o,
	output logic strobe_oe,
	input wire logic io_strobe_n_i,
	output logic io_strobe_n_o,
	input wire logic rd_n_i,
	output logic rd_n_o,
	input wire logic wr_n_i,
	output logic wr_n_o,
	input wire logic ce_wait_n,
	input wire logic rdy,
	input wire logic opcode_fetch_n,
	input wire logic bus_claim_n_i,
	output logic bus_claim_n_o,
	output logic bus_claim_oe,
	input wire logic grant_chain_in_n,
	output logic grant_chain_out_n,
	input wire logic irq_chain_in,
	output logic irq_chain_out,
	output logic int_n_o,
	output logic int_oe
);
	typedef enum logic [3:0] {
		ST_IDLE, ST_REQ, ST_RD_A, ST_RD_S, ST_WR_A, ST_WR_S,
		ST_NEXT, ST_HOLD, ST_REL
	} scd_state_t;

	scd_state_t st_q;
	logic [13:0] follow_q;
	logic [15:0] a_start_q, b_start_q, a_addr_q, b_addr_q, len_q, cnt_q;
	logic [7:0] mask_q, match_q, ictl_q, poff_q, vbase_q, xbyte_q, rr_byte;
	logic [6:0] rmask_q;
	logic [2:0] rd_idx_q;
	logic [1:0] op_q, mode_q;
	logic a_src_q, a_io_q, a_inc_q, a_fix_q, b_io_q, b_inc_q, b_fix_q;
	logic stop_m_q, rdy_hi_q, wait_en_q, auto_q, int_en_q, en_q;
	logic ph_q, cur_m_q, prev_m_q, prev_mv_q, stop_q, done_q;
	logic s_op_q, s_match_q, s_eob_q, sel_q;
	scd_pkg::scd_cause_t ev_q, ie;
	logic wr_ev, rd_ev, base_ev, sel, own, rdy_act, wait_act, start;
	logic last, hit, cur_io, pulse, irq_req, ack_act, in_svc, ip;
	logic [7:0] wr_byte, vec;
	logic [3:0] slot;
	logic [2:0] grp;
	logic av_go, cmd_clr, stb, wph;

	function automatic logic [2:0] grp_of(input logic [7:0] b);
		logic [2:0] g;
		if (!b[7]) begin
			if (b[1:0] != 2'h0) g = 3'h0;
			else if (b[2]) g = 3'h1;
			else g = 3'h2;
		end else begin
			g = {1'b0, b[1:0]} + 3'h3;
		end
		return g;
	endfunction

	function automatic logic [3:0] first_slot(input logic [13:0] f);
		logic [3:0] s;
		s = 4'h0;
		for (int i = scd_pkg::NSLOT - 1; i >= 0; i--) begin
			if (f[i]) s = 4'(i);
		end
		return s;
	endfunction

	function automatic logic [2:0] next_rr(input logic [2:0] idx,
		input logic [6:0] m);
		logic [2:0] n, j;
		logic found;
		n = idx;
		j = idx;
		found = 1'b0;
		for (int i = 0; i < scd_pkg::NRR; i++) begin
			j = (j == 3'(scd_pkg::NRR - 1)) ? 3'h0 : j + 3'h1;
			if (m[j] && !found) begin
				n = j;
				found = 1'b1;
			end
		end
		return n;
	endfunction

	function automatic logic [15:0] step(input logic [15:0] a,
		input logic fix, input logic inc);
		return fix ? a : (inc ? a + 16'h0001 : a - 16'h0001);
	endfunction

	assign av_go = !avs_waitrequest && avs_address == scd_pkg::AV_DATA;
	// CPU pin select only while idle; during ownership it is the wait line
	assign sel = !ce_wait_n && !io_strobe_n_i && opcode_fetch_n &&
		(!rd_n_i || !wr_n_i) && st_q == ST_IDLE; // RQ16
	assign wr_ev = (av_go && avs_write && avs_byteenable[0] &&
		st_q == ST_IDLE) || (sel && !sel_q && !wr_n_i); // RQ12
	assign wr_byte = (av_go && avs_write) ? avs_writedata[7:0] : data_i;
	assign rd_ev = (avs_read && avs_waitrequest &&
		avs_address == scd_pkg::AV_DATA) || (sel && !sel_q && !rd_n_i);
	assign base_ev = wr_ev && follow_q == '0;
	assign slot = first_slot(follow_q);
	assign grp = grp_of(wr_byte);
	assign own = st_q inside {ST_RD_A, ST_RD_S, ST_WR_A, ST_WR_S, ST_NEXT,
		ST_HOLD};
	assign rdy_act = rdy ~^ rdy_hi_q; // RQ19
	assign wait_act = wait_en_q && !ce_wait_n; // RQ11
	assign start = st_q == ST_IDLE && en_q && rdy_act && bus_claim_n_i;
	assign last = cnt_q == len_q; // RQ22
	assign hit = op_q != scd_pkg::OP_XFER && prev_mv_q && prev_m_q; // RQ3
	assign cur_io = (st_q inside {ST_RD_A, ST_RD_S}) == a_src_q ?
		a_io_q : b_io_q;
	assign ie = '{rdy: ictl_q[scd_pkg::IC_RDY],
		match: ictl_q[scd_pkg::IC_MATCH], eob: ictl_q[scd_pkg::IC_EOB]};
	assign cmd_clr = base_ev && grp == 3'h6 && wr_byte == scd_pkg::CMD_RESET;
	assign stb = st_q inside {ST_RD_S, ST_WR_S};
	assign wph = st_q inside {ST_WR_A, ST_WR_S};

	always_comb begin
		case (rd_idx_q)
		3'h0: rr_byte = {2'h0, s_eob_q, s_match_q, ip, 1'b0, rdy_act, s_op_q};
		3'h1: rr_byte = cnt_q[7:0];
		3'h2: rr_byte = cnt_q[15:8];
		3'h3: rr_byte = a_addr_q[7:0];
		3'h4: rr_byte = a_addr_q[15:8];
		3'h5: rr_byte = b_addr_q[7:0];
		3'h6: rr_byte = b_addr_q[15:8];
		default: rr_byte = 8'h00;
		endcase
	end

	// Control byte decoder: base bytes arm slots, later bytes fill them
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			follow_q <= '0;
			a_start_q <= '0;
			b_start_q <= '0;
			len_q <= '0;
			{mask_q, match_q, ictl_q, poff_q, vbase_q} <= '0;
			rmask_q <= '1;
			{op_q, mode_q} <= '0;
			{a_src_q, a_io_q, a_inc_q, a_fix_q} <= '0;
			{b_io_q, b_inc_q, b_fix_q, stop_m_q} <= '0;
			{rdy_hi_q, wait_en_q, auto_q, int_en_q} <= '0;
		end else if (wr_ev && follow_q != '0) begin
			follow_q[slot] <= 1'b0; // RQ26
			case (slot)
			scd_pkg::SL_AL: a_start_q[7:0] <= wr_byte;
			scd_pkg::SL_AH: a_start_q[15:8] <= wr_byte;
			scd_pkg::SL_LL: len_q[7:0] <= wr_byte; // RQ24
			scd_pkg::SL_LH: len_q[15:8] <= wr_byte;
			scd_pkg::SL_MASK: mask_q <= wr_byte;
			scd_pkg::SL_MATCH: match_q <= wr_byte;
			scd_pkg::SL_BL: b_start_q[7:0] <= wr_byte;
			scd_pkg::SL_BH: b_start_q[15:8] <= wr_byte;
			scd_pkg::SL_ICTL: begin
				ictl_q <= wr_byte; // RQ1
				follow_q[scd_pkg::SL_PULSE] <= wr_byte[scd_pkg::IC_PFOL];
				follow_q[scd_pkg::SL_VEC] <= wr_byte[scd_pkg::IC_VFOL];
			end
			scd_pkg::SL_PULSE: poff_q <= wr_byte;
			scd_pkg::SL_VEC: vbase_q <= wr_byte;
			scd_pkg::SL_RMASK: rmask_q <= wr_byte[6:0];
			default: ;
			endcase
		end else if (base_ev) begin
			case (grp) // RQ20
			3'h0: begin
				a_src_q <= wr_byte[scd_pkg::B0_SRC_A];
				op_q <= wr_byte[1:0];
				follow_q[scd_pkg::SL_LH:scd_pkg::SL_AL] <=
					wr_byte[scd_pkg::B0_FOL +: 4];
			end
			3'h1: begin
				a_io_q <= wr_byte[scd_pkg::BP_IO];
				a_inc_q <= wr_byte[scd_pkg::BP_INC];
				a_fix_q <= wr_byte[scd_pkg::BP_FIX];
				follow_q[scd_pkg::SL_TA] <= wr_byte[scd_pkg::BP_TIM];
			end
			3'h2: begin
				b_io_q <= wr_byte[scd_pkg::BP_IO];
				b_inc_q <= wr_byte[scd_pkg::BP_INC];
				b_fix_q <= wr_byte[scd_pkg::BP_FIX];
				follow_q[scd_pkg::SL_TB] <= wr_byte[scd_pkg::BP_TIM];
			end
			3'h3: begin
				stop_m_q <= wr_byte[scd_pkg::B3_STOP];
				follow_q[scd_pkg::SL_MASK] <= wr_byte[scd_pkg::B3_MASK];
				follow_q[scd_pkg::SL_MATCH] <= wr_byte[scd_pkg::B3_MATCH];
			end
			3'h4: begin
				mode_q <= wr_byte[scd_pkg::B4_MODE +: 2];
				follow_q[scd_pkg::SL_BL] <= wr_byte[scd_pkg::B4_BL];
				follow_q[scd_pkg::SL_BH] <= wr_byte[scd_pkg::B4_BH];
				follow_q[scd_pkg::SL_ICTL] <= wr_byte[scd_pkg::B4_ICTL];
			end
			3'h5: begin
				rdy_hi_q <= wr_byte[scd_pkg::B5_RDYHI]; // RQ19
				wait_en_q <= wr_byte[scd_pkg::B5_WAIT]; // RQ11
				auto_q <= wr_byte[scd_pkg::B5_AUTO];
			end
			default: begin
				if (wr_byte == scd_pkg::CMD_RMASK)
					follow_q[scd_pkg::SL_RMASK] <= 1'b1;
				if (wr_byte == scd_pkg::CMD_IEN)
					int_en_q <= 1'b1;
				if (wr_byte == scd_pkg::CMD_IDIS)
					int_en_q <= 1'b0;
			end
			endcase
		end
	end

	// Any control byte disables; only the enable command re-arms
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			en_q <= 1'b0; // RQ25
		end else if (base_ev && grp == 3'h6 && wr_byte == scd_pkg::CMD_ENABLE) begin
			en_q <= 1'b1;
		end else if (wr_ev || stop_q) begin
			en_q <= 1'b0; // RQ25
		end
	end

	// Transfer engine
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			st_q <= ST_IDLE;
			{ph_q, cur_m_q, prev_m_q, prev_mv_q, stop_q, done_q} <= '0;
			a_addr_q <= '0;
			b_addr_q <= '0;
			cnt_q <= '0;
			xbyte_q <= '0;
			ev_q <= '0;
		end else begin
			ev_q <= '0;
			stop_q <= 1'b0;
			done_q <= 1'b0;
			if (base_ev && grp == 3'h6 && wr_byte == scd_pkg::CMD_LOAD) begin
				if (a_src_q || !a_fix_q) a_addr_q <= a_start_q;
				if (!a_src_q || !b_fix_q) b_addr_q <= b_start_q;
				cnt_q <= '0;
				prev_mv_q <= 1'b0;
			end else if (base_ev && grp == 3'h6 &&
				wr_byte == scd_pkg::CMD_CONT) begin
				cnt_q <= '0;
				prev_mv_q <= 1'b0;
			end
			case (st_q)
			ST_IDLE: if (start) begin // RQ10
				st_q <= ST_REQ;
				ev_q.rdy <= 1'b1; // RQ1
			end
			ST_REQ: if (!grant_chain_in_n) st_q <= ST_RD_A; // RQ8
			ST_RD_A: st_q <= ST_RD_S;
			ST_RD_S: if (!ph_q) begin
				ph_q <= 1'b1;
			end else if (!wait_act) begin // RQ11
				ph_q <= 1'b0;
				xbyte_q <= data_i;
				cur_m_q <= ((data_i ^ match_q) & ~mask_q) == 8'h00;
				st_q <= op_q == scd_pkg::OP_SRCH ? ST_NEXT : ST_WR_A;
			end
			ST_WR_A: st_q <= ST_WR_S;
			ST_WR_S: if (!ph_q) begin
				ph_q <= 1'b1;
			end else if (!wait_act) begin
				ph_q <= 1'b0;
				st_q <= ST_NEXT;
			end
			ST_NEXT: begin
				cnt_q <= cnt_q + 16'h0001; // RQ22
				done_q <= 1'b1;
				a_addr_q <= step(a_addr_q, a_fix_q, a_inc_q);
				b_addr_q <= step(b_addr_q, b_fix_q, b_inc_q);
				prev_m_q <= cur_m_q;
				prev_mv_q <= 1'b1;
				ev_q.eob <= last;
				ev_q.match <= hit; // RQ3
				st_q <= ST_REL;
				if (last) begin // RQ24
					stop_q <= !auto_q;
					if (auto_q) begin
						a_addr_q <= a_start_q;
						b_addr_q <= b_start_q;
						cnt_q <= '0;
						prev_mv_q <= 1'b0;
					end
				end else if (hit && stop_m_q) begin
					stop_q <= 1'b1;
				end else if (mode_q == scd_pkg::MODE_CONT) begin
					st_q <= rdy_act ? ST_RD_A : ST_HOLD; // RQ23
				end else if (mode_q == scd_pkg::MODE_BURST && rdy_act) begin
					st_q <= ST_RD_A; // RQ23
				end
			end
			ST_HOLD: if (rdy_act) st_q <= ST_RD_A;
			ST_REL: st_q <= ST_IDLE;
			default: st_q <= ST_IDLE;
			endcase
		end
	end

	// Status flags: a set in the same cycle as a clear wins
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			{s_op_q, s_match_q, s_eob_q} <= '0;
		end else begin
			s_op_q <= done_q || (s_op_q && !cmd_clr);
			s_match_q <= ev_q.match || (s_match_q && !cmd_clr);
			s_eob_q <= ev_q.eob || (s_eob_q && !cmd_clr);
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			rd_idx_q <= '0;
		end else if (base_ev && grp == 3'h6 && wr_byte == scd_pkg::CMD_RDSEQ) begin
			rd_idx_q <= next_rr(3'(scd_pkg::NRR - 1), rmask_q); // RQ21
		end else if (base_ev && grp == 3'h6 && wr_byte == scd_pkg::CMD_RSTAT) begin
			rd_idx_q <= '0;
		end else if (rd_ev) begin
			rd_idx_q <= next_rr(rd_idx_q, rmask_q); // RQ21
		end
	end

	// Avalon slave: every access answers on its second cycle
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			avs_waitrequest <= 1'b1;
			avs_readdata <= '0;
		end else if (!avs_waitrequest) begin
			avs_waitrequest <= 1'b1;
		end else if (avs_read || avs_write) begin
			avs_waitrequest <= 1'b0;
			avs_readdata <= '0;
			if (avs_address == scd_pkg::AV_DATA)
				avs_readdata[7:0] <= rr_byte;
			if (avs_address == scd_pkg::AV_STATE) begin
				avs_readdata[scd_pkg::W_EN] <= en_q;
				avs_readdata[scd_pkg::W_OWN] <= own;
				avs_readdata[scd_pkg::W_SVC] <= in_svc;
				avs_readdata[scd_pkg::W_IP] <= ip;
			end
		end
	end

	// System bus pins follow the engine state one cycle later
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			addr_o <= '0;
			{addr_oe, strobe_oe, data_oe, bus_claim_oe, int_oe} <= '0;
			{mem_strobe_n_o, io_strobe_n_o, rd_n_o, wr_n_o} <= '1;
			{bus_claim_n_o, int_n_o} <= '0;
			grant_chain_out_n <= 1'b1;
			data_o <= '0;
			sel_q <= 1'b0;
		end else begin
			sel_q <= sel;
			addr_oe <= own; // RQ7
			strobe_oe <= own; // RQ18
			addr_o <= wph == a_src_q ? b_addr_q : a_addr_q; // RQ7
			mem_strobe_n_o <= !(stb && !cur_io); // RQ17
			io_strobe_n_o <= !(stb && cur_io); // RQ16
			rd_n_o <= st_q != ST_RD_S; // RQ18
			wr_n_o <= st_q != ST_WR_S;
			bus_claim_oe <= st_q != ST_IDLE || start; // RQ10
			grant_chain_out_n <= grant_chain_in_n || start ||
				st_q != ST_IDLE; // RQ9
			int_oe <= irq_req || (pulse && own &&
				ictl_q[scd_pkg::IC_PULSE]); // RQ6
			data_oe <= (wph && own) || ack_act ||
				(sel && !rd_n_i); // RQ4
			if (wph) data_o <= xbyte_q;
			else if (ack_act) data_o <= vec; // RQ4
			else if (sel && !sel_q && !rd_n_i) data_o <= rr_byte;
		end
	end

	scd_irq u_irq (
		.core_clk(core_clk),
		.arst_n(arst_n),
		.cause(ev_q),
		.ie(ie),
		.int_en(int_en_q),
		.sav(ictl_q[scd_pkg::IC_SAV]),
		.vec_base(vbase_q),
		.clr_ip(cmd_clr),
		.io_strobe_n_i(io_strobe_n_i),
		.rd_n_i(rd_n_i),
		.opcode_fetch_n(opcode_fetch_n),
		.data_i(data_i),
		.irq_chain_in(irq_chain_in),
		.irq_req(irq_req),
		.ack_act(ack_act),
		.in_svc(in_svc),
		.ip(ip),
		.vec(vec),
		.irq_chain_out(irq_chain_out)
	);

	scd_pulse #(.W(8)) u_pulse (
		.core_clk(core_clk),
		.arst_n(arst_n),
		.start(base_ev && grp == 3'h6 && (wr_byte == scd_pkg::CMD_LOAD ||
			wr_byte == scd_pkg::CMD_CONT)),
		.step(done_q),
		.offset(poff_q),
		.pulse(pulse)
	);
endmodule
`default_nettype wire

// ### rtl/scd_irq.sv
// Interrupt pending, acknowledge, vector and return detection
`timescale 1ns/10ps
`default_nettype none
module scd_irq (
	input wire logic core_clk,
	input wire logic arst_n,
	input wire scd_pkg::scd_cause_t cause,
	input wire scd_pkg::scd_cause_t ie,
	input wire logic int_en,
	input wire logic sav,
	input wire logic [7:0] vec_base,
	input wire logic clr_ip,
	input wire logic io_strobe_n_i,
	input wire logic rd_n_i,
	input wire logic opcode_fetch_n,
	input wire logic [7:0] data_i,
	input wire logic irq_chain_in,
	output logic irq_req,
	output logic ack_act,
	output logic in_svc,
	output logic ip,
	output logic [7:0] vec,
	output logic irq_chain_out
);
	logic set;
	logic ack_win;
	logic ack_start;
	logic fetch_ev;
	logic fetch_q;
	logic ed_q;
	logic [1:0] code_q;

	assign set = int_en && |(cause & ie); // RQ2
	assign ack_win = !io_strobe_n_i && !opcode_fetch_n; // RQ14
	assign ack_start = ack_win && !ack_act && ip && irq_chain_in;
	assign fetch_ev = !opcode_fetch_n && !rd_n_i && !fetch_q;

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			ip <= 1'b0;
			code_q <= '0;
		end else begin
			ip <= set || (ip && !clr_ip && !ack_start); // RQ2
			if (set) begin
				code_q <= {cause.eob, cause.match};
			end
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			ack_act <= 1'b0;
			in_svc <= 1'b0;
			fetch_q <= 1'b0;
			ed_q <= 1'b0;
		end else begin
			ack_act <= ack_win && (ack_act || ack_start); // RQ4
			fetch_q <= !opcode_fetch_n && !rd_n_i;
			if (fetch_ev) begin
				ed_q <= (data_i == scd_pkg::RET_OP1); // RQ15
			end
			if (ack_start) begin
				in_svc <= 1'b1;
			end else if (fetch_ev && ed_q && data_i == scd_pkg::RET_OP2) begin
				in_svc <= 1'b0; // RQ15
			end
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			irq_req <= 1'b0;
			irq_chain_out <= 1'b0;
			vec <= '0;
		end else begin
			irq_req <= ip && irq_chain_in && !ack_act; // RQ14
			irq_chain_out <= irq_chain_in && !in_svc; // RQ13
			vec <= vec_base;
			if (sav) begin
				vec[scd_pkg::VEC_LSB +: 2] <= code_q; // RQ2
			end
		end
	end
endmodule
`default_nettype wire

// ### rtl/scd_pkg.sv
// Shared constants and types for the single channel DMA controller
package scd_pkg;
	// Avalon-MM byte offsets
	localparam logic [3:0] AV_DATA = 4'h0;
	localparam logic [3:0] AV_STATE = 4'h4;
	// Associated register slots, listed in load order
	localparam int SL_AL = 0, SL_AH = 1, SL_LL = 2, SL_LH = 3;
	localparam int SL_TA = 4, SL_TB = 5, SL_MASK = 6, SL_MATCH = 7;
	localparam int SL_BL = 8, SL_BH = 9, SL_ICTL = 10, SL_PULSE = 11;
	localparam int SL_VEC = 12, SL_RMASK = 13, NSLOT = 14;
	localparam int NRR = 7;
	// Base register fields
	localparam int B0_SRC_A = 2, B0_FOL = 3;
	localparam int BP_IO = 3, BP_INC = 4, BP_FIX = 5, BP_TIM = 6;
	localparam int B3_STOP = 2, B3_MASK = 3, B3_MATCH = 4;
	localparam int B4_BL = 2, B4_BH = 3, B4_ICTL = 4, B4_MODE = 5;
	localparam int B5_RDYHI = 3, B5_WAIT = 4, B5_AUTO = 5;
	// Interrupt control byte fields
	localparam int IC_MATCH = 0, IC_EOB = 1, IC_PULSE = 2, IC_PFOL = 3;
	localparam int IC_VFOL = 4, IC_SAV = 5, IC_RDY = 6;
	// Status byte and state word fields
	localparam int S_OP = 0, S_RDY = 1, S_IP = 3, S_MATCH = 4, S_EOB = 5;
	localparam int W_EN = 0, W_OWN = 1, W_SVC = 2, W_IP = 3;
	localparam int VEC_LSB = 1;
	localparam logic [1:0] MODE_BYTE = 2'h0;
	localparam logic [1:0] MODE_CONT = 2'h1;
	localparam logic [1:0] MODE_BURST = 2'h2;
	localparam logic [1:0] OP_XFER = 2'h1;
	localparam logic [1:0] OP_SRCH = 2'h2;
	// Group six command bytes
	localparam logic [7:0] CMD_LOAD = 8'hCF;
	localparam logic [7:0] CMD_ENABLE = 8'h87;
	localparam logic [7:0] CMD_DISABLE = 8'h83;
	localparam logic [7:0] CMD_RESET = 8'hC3;
	localparam logic [7:0] CMD_CONT = 8'hD3;
	localparam logic [7:0] CMD_RMASK = 8'hBB;
	localparam logic [7:0] CMD_RDSEQ = 8'hA7;
	localparam logic [7:0] CMD_RSTAT = 8'hBF;
	localparam logic [7:0] CMD_IEN = 8'hAB;
	localparam logic [7:0] CMD_IDIS = 8'hAF;
	// Return-from-interrupt opcode pair
	localparam logic [7:0] RET_OP1 = 8'hED;
	localparam logic [7:0] RET_OP2 = 8'h4D;
	typedef struct packed {
		logic rdy;
		logic match;
		logic eob;
	} scd_cause_t;
endpackage

// ### rtl/scd_pulse.sv
// Byte-count pulse generator with programmable first interval
`timescale 1ns/10ps
`default_nettype none
module scd_pulse #(
	parameter int W = 8
) (
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic start,
	input wire logic step,
	input wire logic [W-1:0] offset,
	output logic pulse
);
	logic [W-1:0] cnt_q;

	// Preset to minus offset so the first wrap comes after offset bytes
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_q <= '0;
			pulse <= 1'b0;
		end else begin
			pulse <= step && (cnt_q == '1); // RQ5
			if (start) begin
				cnt_q <= W'(0) - offset; // RQ5
			end else if (step) begin
				cnt_q <= cnt_q + W'(1);
			end
		end
	end
endmodule
`default_nettype wire

// ### test/scd_dma_monitor.sv
// Port-level checks on the DMA controller, bound into scd_dma
`timescale 1ns/10ps
`default_nettype none
module scd_dma_monitor (
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic avs_waitrequest,
	input wire logic rd_n_o,
	input wire logic wr_n_o,
	input wire logic mem_strobe_n_o,
	input wire logic strobe_oe,
	input wire logic addr_oe,
	input wire logic bus_claim_oe,
	input wire logic bus_claim_n_i,
	input wire logic grant_chain_out_n,
	input wire logic irq_chain_in,
	input wire logic irq_chain_out,
	input wire logic io_strobe_n_i,
	input wire logic opcode_fetch_n,
	input wire logic int_oe,
	input wire logic data_oe
);
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (!arst_n);
	sequence s_rd_fall;
		$fell(rd_n_o);
	endsequence
	sequence s_wr_fall;
		$fell(wr_n_o);
	endsequence
	// Ack only counts while idle, so a pulse is never taken for a request
	sequence s_ack;
		!io_strobe_n_i && !opcode_fetch_n && irq_chain_in && int_oe
			&& !strobe_oe;
	endsequence
	take_answer_a: assert property (
		(avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("register access not answered");
	wait_once_a: assert property (
		!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low too long");
	claim_free_a: assert property (
		$rose(bus_claim_oe) |-> $past(bus_claim_n_i))
		else $error("claim while line held by another");
	grant_hold_a: assert property (
		bus_claim_oe && $past(bus_claim_oe) |-> grant_chain_out_n)
		else $error("grant passed on while claiming");
	own_block_a: assert property (
		addr_oe |-> grant_chain_out_n)
		else $error("address driven while grant passed on");
	mem_addr_a: assert property (
		strobe_oe && !mem_strobe_n_o |-> addr_oe)
		else $error("memory strobe without address");
	rw_excl_a: assert property (
		strobe_oe |-> rd_n_o || wr_n_o)
		else $error("read and write strobes together");
	rd_width_a: assert property (
		s_rd_fall |=> !rd_n_o)
		else $error("read strobe shorter than two cycles");
	wr_width_a: assert property (
		s_wr_fall |=> !wr_n_o)
		else $error("write strobe shorter than two cycles");
	chain_follow_a: assert property (
		irq_chain_out |-> $past(irq_chain_in))
		else $error("chain out high without chain in");
	ack_drive_a: assert property (
		s_ack |-> ##2 data_oe)
		else $error("vector not driven on acknowledge");
	svc_block_a: assert property (
		s_ack |-> ##[1:3] !irq_chain_out)
		else $error("chain not blocked while serviced");
endmodule
bind scd_dma scd_dma_monitor mon (.core_clk, .arst_n, .avs_read,
	.avs_write, .avs_waitrequest, .rd_n_o, .wr_n_o, .mem_strobe_n_o,
	.strobe_oe, .addr_oe, .bus_claim_oe, .bus_claim_n_i,
	.grant_chain_out_n, .irq_chain_in, .irq_chain_out, .io_strobe_n_i,
	.opcode_fetch_n, .int_oe, .data_oe);
`default_nettype wire

// ### test/scd_dma_tb.sv
// Self-checking bench for the single channel DMA controller
`timescale 1ns/10ps
`default_nettype none
module scd_dma_tb;
	localparam logic [7:0] VEC = 8'hA0;
	logic core_clk, avs_waitrequest, data_oe, addr_oe, mem_strobe_n_o;
	logic strobe_oe, rd_n_o, wr_n_o, ce_wait_n, bus_claim_oe, grant_n;
	logic grant_chain_out_n, irq_chain_out, int_oe;
	logic arst_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0, rdy = 1'b1;
	logic io_strobe_n_i = 1'b1, rd_n_i = 1'b1, fetch_n = 1'b1;
	logic other = 1'b0, cl_q = 1'b0, io_q = 1'b0;
	logic [3:0] avs_address = 4'h0;
	logic [31:0] avs_writedata = 32'h0000_0000, avs_readdata, r;
	logic [7:0] cpu_d = 8'h00, data_o, sys_rd;
	logic [15:0] addr_o;
	int err_total = 0, checks_done = 0, claims = 0, pulses = 0, wr_cnt;
	integer seed = 90;
	wire logic claim_n = !(bus_claim_oe || other);
	wire logic [7:0] data_i = strobe_oe ? sys_rd : cpu_d;
	scd_dma dut (.core_clk, .arst_n, .avs_address, .avs_read, .avs_write,
		.avs_writedata, .avs_byteenable(4'hF), .avs_readdata,
		.avs_waitrequest, .data_i, .data_o, .data_oe, .addr_o, .addr_oe,
		.mem_strobe_n_o, .strobe_oe, .io_strobe_n_i, .io_strobe_n_o(),
		.rd_n_i, .rd_n_o, .wr_n_i(1'b1), .wr_n_o, .ce_wait_n, .rdy,
		.opcode_fetch_n(fetch_n), .bus_claim_n_i(claim_n),
		.bus_claim_n_o(), .bus_claim_oe, .grant_chain_in_n(grant_n),
		.grant_chain_out_n, .irq_chain_in(1'b1), .irq_chain_out,
		.int_n_o(), .int_oe);
	scd_sys_model sys (.core_clk, .arst_n, .claim_low(bus_claim_oe),
		.addr_o, .strobe_oe, .rd_n_o, .wr_n_o, .data_o, .grant_n,
		.ce_wait_n, .rd_byte(sys_rd), .wr_cnt);
	initial begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		cl_q <= bus_claim_oe;
		if (bus_claim_oe && !cl_q)
			claims <= claims + 1;
		io_q <= int_oe;
		if (int_oe && !io_q && strobe_oe)
			pulses <= pulses + 1;
	end
	function automatic logic [7:0] exp_byte(input logic [15:0] a);
		return a[7:0] ^ a[15:8] ^ 8'h5A;
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic complete_run();
		if (err_total == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// Holds the request until waitrequest is seen low, giving up after 100 cycles
	task automatic av(input logic w, input logic [3:0] a,
		input logic [7:0] d);
		int t = 0;
		avs_address <= a;
		avs_writedata <= {24'h00_0000, d};
		avs_write <= w;
		avs_read <= !w;
		@(posedge core_clk);
		while (avs_waitrequest !== 1'b0 && t < 100) begin
			@(posedge core_clk);
			t++;
		end
		r = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		@(posedge core_clk);
		chk(t < 100, 1'b1);
	endtask
	task automatic xfer(input int m);
		logic [15:0] src, dst;
		logic [7:0] n;
		logic [7:0] prog [$];
		int c0, w0, t;
		src = $random(seed);
		dst = $random(seed);
		n = 8'(($random(seed) & 3) + 1);
		rdy <= (m != 1);
		other <= 1'b1;
		prog = {8'h7D, src[7:0], src[15:8], n, 8'h00, 8'h14, 8'h10,
			8'h8D | (8'(m) << 5) | (m == 2 ? 8'h10 : 8'h00),
			dst[7:0], dst[15:8]};
		if (m == 2)
			prog = {prog, 8'h1E, 8'h01, VEC};
		prog = {prog, (m == 1) ? 8'h92 : 8'h9A, scd_pkg::CMD_LOAD};
		if (m == 2)
			prog.push_back(scd_pkg::CMD_IEN);
		prog.push_back(scd_pkg::CMD_ENABLE);
		foreach (prog[i])
			av(1'b1, scd_pkg::AV_DATA, prog[i]);
		c0 = claims;
		w0 = wr_cnt;
		repeat (20) @(posedge core_clk);
		chk(claims - c0, 0);
		av(1'b0, scd_pkg::AV_STATE, 8'h00);
		chk(r & 32'h3, 32'h1);
		other <= 1'b0;
		t = 0;
		while (wr_cnt - w0 < n + 1 && t < 3000) begin
			@(posedge core_clk);
			t++;
		end
		repeat (30) @(posedge core_clk);
		chk(wr_cnt - w0, n + 1);
		chk(claims - c0, m == 0 ? n + 1 : 1);
		for (int i = 0; i <= n; i++)
			chk(sys.mem[8'(dst + i)], exp_byte(src + 16'(i)));
	endtask
	task automatic fetch_byte(input logic [7:0] b);
		fetch_n <= 1'b0;
		rd_n_i <= 1'b0;
		cpu_d <= b;
		@(posedge core_clk);
		fetch_n <= 1'b1;
		rd_n_i <= 1'b1;
		cpu_d <= ~b;
		@(posedge core_clk);
	endtask
	initial begin
		#600000;
		err_total++;
		complete_run();
	end
	initial begin
		repeat (16) @(posedge core_clk);
		arst_n <= 1'b1;
		@(posedge core_clk);
		av(1'b0, scd_pkg::AV_STATE, 8'h00);
		chk(r, 32'h0000_0000);
		av(1'b0, 4'h8, 8'h00);
		chk(r, 32'h0000_0000);
		for (int m = 0; m < 3; m++)
			xfer(m);
		chk(pulses, 1);
		av(1'b1, scd_pkg::AV_DATA, scd_pkg::CMD_RSTAT);
		av(1'b0, scd_pkg::AV_DATA, 8'h00);
		chk(r & 32'h28, 32'h28);
		av(1'b0, scd_pkg::AV_STATE, 8'h00);
		chk(r & 32'h8, 32'h8);
		chk(int_oe, 1'b1);
		io_strobe_n_i <= 1'b0;
		fetch_n <= 1'b0;
		repeat (3) @(posedge core_clk);
		chk(data_oe, 1'b1);
		chk(data_o, VEC);
		io_strobe_n_i <= 1'b1;
		fetch_n <= 1'b1;
		repeat (3) @(posedge core_clk);
		chk(int_oe, 1'b0);
		chk(irq_chain_out, 1'b0);
		fetch_byte(scd_pkg::RET_OP1);
		fetch_byte(scd_pkg::RET_OP2);
		repeat (3) @(posedge core_clk);
		chk(irq_chain_out, 1'b1);
		complete_run();
	end
endmodule
`default_nettype wire

// ### test/scd_sys_model.sv
// Processor grant and memory on the controller's system bus side
`timescale 1ns/10ps
`default_nettype none
module scd_sys_model (
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic claim_low,
	input wire logic [15:0] addr_o,
	input wire logic strobe_oe,
	input wire logic rd_n_o,
	input wire logic wr_n_o,
	input wire logic [7:0] data_o,
	output logic grant_n,
	output logic ce_wait_n,
	output logic [7:0] rd_byte,
	output int wr_cnt
);
	logic [7:0] mem [0:255];
	logic [7:0] last_q;
	logic wr_q;
	integer seed = 90, r;
	// Released bus shows a changing pattern, never the last byte
	assign rd_byte = (strobe_oe && !rd_n_o) ?
		(addr_o[7:0] ^ addr_o[15:8] ^ 8'h5A) : ~last_q;
	always @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			grant_n <= 1'b1;
			ce_wait_n <= 1'b1;
			wr_q <= 1'b1;
			wr_cnt <= 0;
			last_q <= 8'h00;
		end else begin
			r = $random(seed);
			last_q <= rd_byte;
			grant_n <= !(claim_low && (!grant_n || r[0]));
			ce_wait_n <= !(strobe_oe && r[2:1] == 2'h0);
			wr_q <= wr_n_o || !strobe_oe;
			if (strobe_oe && !wr_n_o)
				mem[addr_o[7:0]] <= data_o;
			if (strobe_oe && !wr_n_o && wr_q)
				wr_cnt <= wr_cnt + 1;
		end
	end
endmodule
`default_nettype wire
